// >>> sff_front_end.sv
// Serial flash command front end: SPI link, pause, write guard and both status registers.
`timescale 1ns/10ps
// How it works
// - Host drives opcode, address, data on line zero; sampled on rising clock.
// - Standard-mode read and status bits leave on line one at falling edge.
// - Dual reads turn lines zero and one bidirectional, two bits per clock.
// - Quad reads move four bits per clock for the four quad read opcodes.
// - Quad opcodes use lines two and three; accepted only with quad enable set.
// - Pause exists only in standard and dual operation, never during quad.
// - Pause starts at pause pin fall if clock low, else next falling edge.
// - Pause ends at pause pin rise if clock low, else next falling edge.
// - While paused: output floats, inputs ignored, partial instruction kept.
// - After power-up write opcodes are rejected for a delay; nothing during reset.
// - Write latch cleared at power-up; write enable must precede write opcodes.
// - Write latch clears automatically when program, erase or status write finishes.
// - In deep power-down only release-from-power-down is obeyed.
// - Status writes need write latch, guard bits and write-protect pin permission.
// - Status bit 0 is busy, set during program, erase, status write.
// - While busy only status-one read is obeyed.
// - Status bit 1 is the write latch; write enable sets, writes clear.
// - Status bits 4..2 are block guard bits, written by status write, reset zero.
// - Guard bits can cover one 4KB sector up to the whole array.
// - Status bit 9 is quad enable; when set lines two, three replace pins.
// - With both status guards zero the pin is ignored; latch alone suffices.
module sff_front_end #(
   parameter int PUW_TIME_US   = 10,
   parameter int WRSR_TIME_US  = 100,
   parameter int PROG_TIME_US  = 100,
   parameter int ERASE_TIME_US = 1000
) (
   input  wire logic       core_clk_in,
   input  wire logic       rstn_in,
   input  wire logic       spi_clk_in,
   input  wire logic       cs_n_in,
   input  wire logic [3:0] line_in,
   output logic      [3:0] line_out,
   output logic      [3:0] line_oe_out
);

   localparam logic [31:0] PUW_CYC   = 32'((PUW_TIME_US * 1000) / sff_pkg::CLK_PERIOD_NS);
   localparam logic [31:0] WRSR_CYC  = 32'((WRSR_TIME_US * 1000) / sff_pkg::CLK_PERIOD_NS);
   localparam logic [31:0] PROG_CYC  = 32'((PROG_TIME_US * 1000) / sff_pkg::CLK_PERIOD_NS);
   localparam logic [31:0] ERASE_CYC = 32'((ERASE_TIME_US * 1000) / sff_pkg::CLK_PERIOD_NS);

   // Per-opcode lane plan; lead counts clock edges after the opcode before data leaves.
   function automatic sff_pkg::sff_op_t op_info(input logic [7:0] opc);
      sff_pkg::sff_op_t i;
      i = '{rd: 1'b0, stat: 1'b0, aw: sff_pkg::LW1, dw: sff_pkg::LW1,
            lead: sff_pkg::LEAD_NONE, ow: sff_pkg::LW1, quad: 1'b0};
      case (opc)
         sff_pkg::OP_RDSR1, sff_pkg::OP_RDSR2: begin
            i.rd = 1'b1; i.stat = 1'b1; i.lead = 6'h00;
         end
         sff_pkg::OP_RD:  begin i.rd = 1'b1; i.lead = 6'h18; end
         sff_pkg::OP_FRD: begin i.rd = 1'b1; i.lead = 6'h20; end
         sff_pkg::OP_DOR: begin i.rd = 1'b1; i.lead = 6'h20; i.ow = sff_pkg::LW2; end
         sff_pkg::OP_DIO: begin
            i.rd = 1'b1; i.lead = 6'h10; i.aw = sff_pkg::LW2; i.ow = sff_pkg::LW2;
         end
         sff_pkg::OP_QOR: begin
            i.rd = 1'b1; i.lead = 6'h20; i.ow = sff_pkg::LW4; i.quad = 1'b1;
         end
         sff_pkg::OP_QIO, sff_pkg::OP_WQIO, sff_pkg::OP_OQIO: begin
            i.rd = 1'b1; i.aw = sff_pkg::LW4; i.ow = sff_pkg::LW4; i.quad = 1'b1;
            i.lead = (opc == sff_pkg::OP_QIO) ? 6'h0c : ((opc == sff_pkg::OP_WQIO) ? 6'h0a : 6'h08);
         end
         sff_pkg::OP_QPP: begin i.lead = 6'h18; i.dw = sff_pkg::LW4; i.quad = 1'b1; end
         default: ;
      endcase
      return i;
   endfunction : op_info

   // ---------------- Link side, clocked by the host's serial clock ----------------
   sff_pkg::sff_frame_t f_q, f_d;
   sff_pkg::sff_held_t  h_q, h_d;
   sff_pkg::sff_out_t   o_q, o_d;
   sff_pkg::sff_core_t  c_q, c_d;
   sff_pkg::sff_op_t    inf;
   sff_pkg::sff_op_t    nxt_inf;
   sff_pkg::sff_stat_t  stat_src;
   logic                frame_rst_n;
   logic                pause_r;
   logic                paused;
   logic                quad_l;
   logic [2:0]          w;
   logic [2:0]          bn;
   logic [7:0]          sh;
   logic [7:0]          obyte;
   logic [7:0]          sel;

   // Select high clears the frame, so a select pulse inside a pause drops the instruction.
   assign frame_rst_n = rstn_in & ~cs_n_in;
   assign quad_l      = h_q.s2.sr2[sff_pkg::SR2_QUAD];
   assign inf         = op_info(f_q.opc);
   assign nxt_inf     = op_info(sh);
   // Just before a rising edge the clock was low, so the pin level alone decides the pause.
   assign pause_r     = ~quad_l & ~line_in[3];
   // Clock low follows the pin at once; clock high keeps what the last falling edge saw.
   assign paused      = spi_clk_in ? o_q.hold : (~quad_l & ~line_in[3]);
   assign stat_src    = '{sr1: c_q.sr1, sr2: c_q.sr2, pd: c_q.pd};

   always_comb begin
      f_d = f_q;
      h_d = h_q;
      h_d.s1 = stat_src;
      h_d.s2 = h_q.s1;
      w = sff_pkg::LW1;
      if (f_q.opc_done) begin
         w = (f_q.ecnt < inf.lead) ? inf.aw : inf.dw;
      end
      case (w)
         sff_pkg::LW2: sh = {f_q.shf[5:0], line_in[1:0]};
         sff_pkg::LW4: sh = {f_q.shf[3:0], line_in};
         default:      sh = {f_q.shf[6:0], line_in[0]};
      endcase
      bn = 3'(f_q.bitn + w);
      // A mode 3 host raises the clock while deselected; that edge must not touch the held command.
      if (!pause_r && !cs_n_in) begin
         f_d.shf  = sh;
         f_d.bitn = bn;
         h_d.aligned = (bn == 3'h0);
         if (!f_q.started) begin
            f_d.started = 1'b1;
            h_d.seq     = ~h_q.seq;
            h_d.nb      = 3'h0;
         end
         if (!f_q.opc_done) begin
            if (bn == 3'h0) begin
               f_d.opc_done = 1'b1;
               f_d.opc      = sh;
               h_d.opc      = sh;
               f_d.rd_ok    = nxt_inf.rd & ~h_q.s2.pd
                              & (~h_q.s2.sr1[sff_pkg::SR1_BUSY] | sh == sff_pkg::OP_RDSR1)
                              & (~nxt_inf.quad | quad_l);
            end
         end else begin
            if (f_q.ecnt != sff_pkg::LEAD_NONE) begin
               f_d.ecnt = 6'(f_q.ecnt + 6'h01);
            end
            if (inf.rd && f_q.ecnt >= inf.lead) begin
               f_d.obit = 3'(f_q.obit + inf.ow);
            end
            if (bn == 3'h0 && h_q.nb != sff_pkg::NB_MAX) begin
               h_d.nb = 3'(h_q.nb + 3'h1);
               if (h_q.nb == 3'h0) begin
                  h_d.d0 = sh;
               end
               if (h_q.nb == 3'h1) begin
                  h_d.d1 = sh;
               end
            end
         end
      end
   end

   always_ff @(posedge spi_clk_in or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         f_q <= '0;
      end else begin
         f_q <= f_d;
      end
   end

   // Captured command survives select rise; the core reads it once the clock has stopped.
   always_ff @(posedge spi_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         h_q <= '0;
      end else begin
         h_q <= h_d;
      end
   end

   always_comb begin
      o_d      = o_q;
      o_d.hold = ~quad_l & ~line_in[3];
      obyte    = sff_pkg::ERASED_BYTE;
      if (inf.stat) begin
         obyte = (f_q.opc == sff_pkg::OP_RDSR2) ? h_q.s2.sr2 : h_q.s2.sr1;
      end
      sel = obyte << f_q.obit;
      if (!o_d.hold) begin
         o_d.dat = 4'h0;
         o_d.oe  = 4'h0;
         if (f_q.rd_ok && f_q.ecnt >= inf.lead) begin
            case (inf.ow)
               sff_pkg::LW2: begin o_d.dat = {2'h0, sel[7:6]}; o_d.oe = 4'h3; end
               sff_pkg::LW4: begin o_d.dat = sel[7:4];          o_d.oe = 4'hf; end
               default:      begin o_d.dat = {2'h0, sel[7], 1'b0}; o_d.oe = 4'h2; end
            endcase
         end
      end
   end

   always_ff @(negedge spi_clk_in or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         o_q <= '0;
      end else begin
         o_q <= o_d;
      end
   end

   assign line_out    = o_q.dat;
   assign line_oe_out = o_q.oe & {4{~paused}};

   // ---------------- Core side, clocked by the system clock ----------------
   logic cs_rise;
   logic exec;
   logic wr_ok;
   logic busy;
   logic latch;

   assign busy    = c_q.sr1[sff_pkg::SR1_BUSY];
   assign latch   = c_q.sr1[sff_pkg::SR1_LATCH];
   assign cs_rise = c_q.cs_s[1] & ~c_q.cs_s[2];
   // The toggle marks a frame that really clocked; the captured bytes are stable by now.
   assign exec    = cs_rise & (c_q.seq_s[1] != c_q.last_seq) & h_q.aligned;
   // Guard high locks; guard low with the pin low locks unless the pin serves as a data line.
   assign wr_ok   = latch & ~c_q.sr2[sff_pkg::SR2_GHIGH]
                    & ~(c_q.sr1[sff_pkg::SR1_GLOW] & ~c_q.wp_s[1] & ~c_q.sr2[sff_pkg::SR2_QUAD]);

   always_comb begin
      c_d       = c_q;
      c_d.cs_s  = {c_q.cs_s[1:0], cs_n_in};
      c_d.wp_s  = {c_q.wp_s[0], line_in[2]};
      c_d.seq_s = {c_q.seq_s[1:0], h_q.seq};
      if (cs_rise) begin
         c_d.last_seq = c_q.seq_s[1];
      end
      if (!c_q.puw_done) begin
         if (c_q.puw_cnt >= PUW_CYC - 32'h1) begin
            c_d.puw_done = 1'b1;
         end else begin
            c_d.puw_cnt = c_q.puw_cnt + 32'h1;
         end
      end
      if (busy) begin
         if (c_q.busy_cnt <= 32'h1) begin
            c_d.sr1[sff_pkg::SR1_BUSY]  = 1'b0;
            c_d.sr1[sff_pkg::SR1_LATCH] = 1'b0;
         end else begin
            c_d.busy_cnt = c_q.busy_cnt - 32'h1;
         end
      end
      if (exec) begin
         if (c_q.pd) begin
            if (h_q.opc == sff_pkg::OP_RPD) begin
               c_d.pd = 1'b0;
            end
         end else if (!busy) begin
            case (h_q.opc)
               sff_pkg::OP_WREN: begin
                  if (c_q.puw_done && h_q.nb == 3'h0) begin
                     c_d.sr1[sff_pkg::SR1_LATCH] = 1'b1;
                  end
               end
               sff_pkg::OP_WRDIS: c_d.sr1[sff_pkg::SR1_LATCH] = 1'b0;
               sff_pkg::OP_WRSR: begin
                  if (c_q.puw_done && wr_ok && h_q.nb != 3'h0) begin
                     // Guard, sector, bottom and block guard bits; region decode lives in the array.
                     c_d.sr1 = (c_q.sr1 & ~sff_pkg::SR1_WMASK) | (h_q.d0 & sff_pkg::SR1_WMASK);
                     if (h_q.nb >= 3'h2) begin
                        c_d.sr2 = (c_q.sr2 & ~sff_pkg::SR2_WMASK) | (h_q.d1 & sff_pkg::SR2_WMASK);
                     end
                     c_d.sr1[sff_pkg::SR1_BUSY]  = 1'b1;
                     c_d.sr1[sff_pkg::SR1_LATCH] = 1'b0;
                     c_d.busy_cnt = WRSR_CYC;
                  end
               end
               sff_pkg::OP_PP, sff_pkg::OP_QPP: begin
                  if (c_q.puw_done && latch && h_q.nb >= 3'h4
                      && (h_q.opc != sff_pkg::OP_QPP || c_q.sr2[sff_pkg::SR2_QUAD])) begin
                     c_d.sr1[sff_pkg::SR1_BUSY]  = 1'b1;
                     c_d.sr1[sff_pkg::SR1_LATCH] = 1'b0;
                     c_d.busy_cnt = PROG_CYC;
                  end
               end
               sff_pkg::OP_SE, sff_pkg::OP_BE32, sff_pkg::OP_BE64, sff_pkg::OP_CE1, sff_pkg::OP_CE2: begin
                  if (c_q.puw_done && latch && (h_q.nb == 3'h3
                      || (h_q.nb == 3'h0 && (h_q.opc == sff_pkg::OP_CE1 || h_q.opc == sff_pkg::OP_CE2)))) begin
                     c_d.sr1[sff_pkg::SR1_BUSY]  = 1'b1;
                     c_d.sr1[sff_pkg::SR1_LATCH] = 1'b0;
                     c_d.busy_cnt = ERASE_CYC;
                  end
               end
               sff_pkg::OP_PDN: c_d.pd = 1'b1;
               default: ;
            endcase
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         c_q <= '{cs_s: 3'h7, wp_s: 2'h3, seq_s: 3'h0, last_seq: 1'b0,
                  sr1: sff_pkg::SR1_RESET, sr2: sff_pkg::SR2_RESET, pd: 1'b0,
                  puw_done: 1'b0, puw_cnt: 32'h0, busy_cnt: 32'h0};
      end else begin
         c_q <= c_d;
      end
   end

   // ---------------- Checks ----------------
   property p_latch_after_done;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $fell(busy) |-> !latch;
   endproperty
   a_latch_after_done: assert property (p_latch_after_done) else $error("latch still set after busy ended");

   property p_no_wren_early;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (exec && !c_q.puw_done && !latch) |=> !latch;
   endproperty
   a_no_wren_early: assert property (p_no_wren_early) else $error("write latch set during power-up delay");

   property p_pd_ignores;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (c_q.pd && exec && h_q.opc != sff_pkg::OP_RPD) |=> (c_q.pd && $stable(c_q.sr1) && $stable(c_q.sr2));
   endproperty
   a_pd_ignores: assert property (p_pd_ignores) else $error("opcode obeyed in power-down");

   property p_busy_ignores;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (busy && c_q.busy_cnt > 32'h1 && exec) |=> ($stable(c_q.sr1[7:2]) && $stable(c_q.sr2) && $stable(c_q.pd));
   endproperty
   a_busy_ignores: assert property (p_busy_ignores) else $error("opcode obeyed while busy");

   property p_guard_blocks;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (exec && h_q.opc == sff_pkg::OP_WRSR && !wr_ok && !busy) |=> ($stable(c_q.sr1[7:2]) && !busy);
   endproperty
   a_guard_blocks: assert property (p_guard_blocks) else $error("status write passed a closed guard");

   property p_soft_write;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (exec && h_q.opc == sff_pkg::OP_WRSR && latch && !busy && !c_q.pd && c_q.puw_done
       && !c_q.sr1[sff_pkg::SR1_GLOW] && !c_q.sr2[sff_pkg::SR2_GHIGH] && h_q.nb != 3'h0)
      |=> (c_q.sr1[7:2] == $past(h_q.d0[7:2])) && busy && !latch;
   endproperty
   a_soft_write: assert property (p_soft_write) else $error("status write with open guards not applied");

   property p_erase_busy;
      @(posedge core_clk_in) disable iff (!rstn_in)
      (exec && !busy && !c_q.pd && latch && c_q.puw_done && h_q.nb == 3'h0
       && (h_q.opc == sff_pkg::OP_CE1 || h_q.opc == sff_pkg::OP_CE2)) |=> busy ##1 busy;
   endproperty
   a_erase_busy: assert property (p_erase_busy) else $error("erase did not raise busy");

   property p_clean_start;
      @(posedge core_clk_in) disable iff (!rstn_in)
      $rose(c_q.puw_done) |-> !latch && !busy;
   endproperty
   a_clean_start: assert property (p_clean_start) else $error("latch or busy set at end of power-up delay");

   property p_pause_keeps;
      @(posedge spi_clk_in) disable iff (!frame_rst_n)
      pause_r |=> $stable(f_q);
   endproperty
   a_pause_keeps: assert property (p_pause_keeps) else $error("frame advanced while paused");

   c_wrsr_done: cover property (@(posedge core_clk_in) disable iff (!rstn_in)
                                exec && h_q.opc == sff_pkg::OP_WRSR && wr_ok);
   c_erase_run: cover property (@(posedge core_clk_in) disable iff (!rstn_in) $fell(busy));
   c_stat_out:  cover property (@(negedge spi_clk_in) disable iff (!frame_rst_n) o_q.oe == 4'h2);
   c_paused:    cover property (@(posedge spi_clk_in) disable iff (!frame_rst_n) f_q.opc_done && pause_r);

endmodule : sff_front_end

// >>> sff_front_end_test.sv
// Self-checking bench for the serial flash front end.
`timescale 1ns/10ps
module sff_front_end_test;
   logic       clk = 1'b0;
   logic       rstn = 1'b0;
   wire        sclk;
   wire        cs_n;
   wire  [3:0] lines;
   logic [3:0] dout;
   logic [3:0] doe;
   logic [9:0] expq[$];
   logic [7:0] d;
   int         bad_count = 0;
   int         checks_done = 0;

   always #10 clk = ~clk;

   sff_front_end #(.PUW_TIME_US(1), .WRSR_TIME_US(1), .PROG_TIME_US(1), .ERASE_TIME_US(4)) u_dut (
      .core_clk_in(clk), .rstn_in(rstn), .spi_clk_in(sclk), .cs_n_in(cs_n),
      .line_in(lines), .line_out(dout), .line_oe_out(doe));

   sff_host_model u_host (
      .dev_dat_in(dout), .dev_oe_in(doe), .spi_clk_out(sclk), .cs_n_out(cs_n), .line_out(lines));

   task automatic chk(input string what, input logic [9:0] seen, input logic [9:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   task automatic gap(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : gap

   task automatic cmd(input logic [7:0] op, input int n = 0, input logic [7:0] v = 8'h00);
      u_host.frame(op, n, {v, 8'h00}, 1'b0, 1'b0, 1'b0);
      gap(8);
   endtask : cmd

   task automatic rs(input logic [7:0] e, input logic m3 = 1'b0, input logic pz = 1'b0);
      expq.push_back({2'b01, e});
      u_host.frame(sff_pkg::OP_RDSR1, 0, 16'h0000, 1'b1, m3, pz);
      gap(8);
   endtask : rs

   task automatic rx(input logic [7:0] op, input int n, input logic [9:0] e);
      expq.push_back(e);
      u_host.frame(op, n, 16'h0000, 1'b1, 1'b0, 1'b0);
      gap(8);
   endtask : rx

   // The busy time is 50 core cycles in this build, so 70 leaves margin.
   task automatic wrsr(input logic [7:0] v);
      cmd(sff_pkg::OP_WREN);
      cmd(sff_pkg::OP_WRSR, 1, v);
      gap(70);
   endtask : wrsr

   always @(u_host.got) chk("status", u_host.res, expq.pop_front());

   initial begin
      d = 8'($urandom(32'h3feff2eb));
      repeat (20) @(posedge clk);
      #1 rstn = 1'b1;
      cmd(sff_pkg::OP_WREN);
      rs(8'h00);
      $display("test power-up done");
      gap(60);
      cmd(sff_pkg::OP_WRSR, 1, 8'h1c);
      rs(8'h00);
      cmd(sff_pkg::OP_WREN);
      rs(8'h02, 1'b1);
      cmd(sff_pkg::OP_WRDIS);
      rs(8'h00);
      $display("test latch done");
      cmd(sff_pkg::OP_WREN);
      cmd(sff_pkg::OP_CE1);
      rs(8'h01);
      cmd(sff_pkg::OP_WREN);
      rs(8'h01);
      gap(220);
      rs(8'h00);
      $display("test busy done");
      d = 8'($urandom) & 8'h1c;
      wrsr(d);
      rs(d);
      wrsr(8'h80);
      rs(8'h80);
      u_host.wp_n = 1'b0;
      wrsr(8'h00);
      rs(8'h82);
      u_host.wp_n = 1'b1;
      wrsr(8'h00);
      rs(8'h00);
      u_host.wp_n = 1'b0;
      wrsr(8'h0c);
      rs(8'h0c);
      u_host.wp_n = 1'b1;
      $display("test guard done");
      rs(8'h0c, 1'b0, 1'b1);
      $display("test pause done");
      cmd(sff_pkg::OP_PDN);
      cmd(sff_pkg::OP_WREN);
      expq.push_back(10'h000);
      u_host.frame(sff_pkg::OP_RDSR1, 0, 16'h0000, 1'b1, 1'b0, 1'b0);
      gap(8);
      cmd(sff_pkg::OP_RPD);
      rs(8'h0c);
      $display("test power-down done");
      rx(sff_pkg::OP_QOR, 4, 10'h000);
      rx(sff_pkg::OP_DOR, 4, {2'b01, sff_pkg::ERASED_BYTE});
      cmd(sff_pkg::OP_WREN);
      u_host.frame(sff_pkg::OP_WRSR, 2, 16'h0c02, 1'b0, 1'b0, 1'b0);
      gap(78);
      rx(sff_pkg::OP_RDSR2, 0, {2'b01, 8'h02});
      rx(sff_pkg::OP_QOR, 4, {2'b01, sff_pkg::ERASED_BYTE});
      $display("test lanes done");
      gap(10);
      tally_and_finish();
   end

   // About 3000 core cycles of traffic are expected; allow more than twice that.
   initial begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
endmodule : sff_front_end_test

// >>> sff_host_model.sv
// Host SPI controller model that drives the flash front end in standard mode.
`timescale 1ns/10ps
module sff_host_model (
   input  wire logic [3:0] dev_dat_in,
   input  wire logic [3:0] dev_oe_in,
   output logic            spi_clk_out,
   output logic            cs_n_out,
   output logic      [3:0] line_out
);
   logic       mosi = 1'b0;
   logic       flip = 1'b0;
   logic       wp_n = 1'b1;
   logic       pause_n = 1'b1;
   logic [9:0] res = 10'h000;
   event       got;

   initial begin
      spi_clk_out = 1'b0;
      cs_n_out = 1'b1;
   end
   // An undriven line one keeps changing, so stale data never matches by luck.
   always @(spi_clk_out) flip = ~flip;
   assign line_out = {pause_n, wp_n, dev_oe_in[1] ? dev_dat_in[1] : flip, dev_oe_in[0] ? dev_dat_in[0] : mosi};

   // Result is {output seen during pause, answered, byte}.
   task automatic frame(input logic [7:0] op, input int nwr, input logic [15:0] wd,
                        input logic rd, input logic m3, input logic pz);
      logic [23:0] sh;
      int          nb;
      logic        ans;
      logic        bad;
      sh = {op, wd};
      nb = 8 * (1 + nwr) + (rd ? 8 : 0);
      ans = rd;
      bad = 1'b0;
      res = 10'h000;
      spi_clk_out = m3;
      #7 cs_n_out = 1'b0;
      for (int i = 0; i < nb; i++) begin
         spi_clk_out = 1'b0;
         mosi = sh[23];
         sh = sh << 1;
         if (pz && i == nb - 4) begin
            #12 pause_n = 1'b0;
            #12 bad = dev_oe_in[1];
            repeat (2) begin
               #24 spi_clk_out = 1'b1;
               #24 spi_clk_out = 1'b0;
            end
            #12 pause_n = 1'b1;
         end
         #24 spi_clk_out = 1'b1;
         if (rd && i >= nb - 8) begin
            ans &= dev_oe_in[1];
            res[7:0] = {res[6:0], dev_dat_in[1]};
         end
         #24;
      end
      spi_clk_out = m3;
      #24 cs_n_out = 1'b1;
      mosi = 1'b0;
      if (rd) begin
         res = ans ? {bad, 1'b1, res[7:0]} : {bad, 9'h000};
         -> got;
      end
   endtask : frame
endmodule : sff_host_model

// >>> sff_pkg.sv
// Opcodes, status layout, timing and state types for the serial flash front end.
package sff_pkg;

   // Opcodes.
   localparam logic [7:0] OP_WREN  = 8'h06;
   localparam logic [7:0] OP_WRDIS = 8'h04;
   localparam logic [7:0] OP_RDSR1 = 8'h05;
   localparam logic [7:0] OP_RDSR2 = 8'h35;
   localparam logic [7:0] OP_WRSR  = 8'h01;
   localparam logic [7:0] OP_PP    = 8'h02;
   localparam logic [7:0] OP_QPP   = 8'h32;
   localparam logic [7:0] OP_SE    = 8'h20;
   localparam logic [7:0] OP_BE32  = 8'h52;
   localparam logic [7:0] OP_BE64  = 8'hd8;
   localparam logic [7:0] OP_CE1   = 8'hc7;
   localparam logic [7:0] OP_CE2   = 8'h60;
   localparam logic [7:0] OP_PDN   = 8'hb9;
   localparam logic [7:0] OP_RPD   = 8'hab;
   localparam logic [7:0] OP_RD    = 8'h03;
   localparam logic [7:0] OP_FRD   = 8'h0b;
   localparam logic [7:0] OP_DOR   = 8'h3b;
   localparam logic [7:0] OP_DIO   = 8'hbb;
   localparam logic [7:0] OP_QOR   = 8'h6b;
   localparam logic [7:0] OP_QIO   = 8'heb;
   localparam logic [7:0] OP_WQIO  = 8'he7;
   localparam logic [7:0] OP_OQIO  = 8'he3;

   // Status bit positions: first byte, then second byte.
   localparam int SR1_BUSY  = 0;
   localparam int SR1_LATCH = 1;
   localparam int SR1_GLOW  = 7;
   localparam int SR2_GHIGH = 0;
   localparam int SR2_QUAD  = 1;
   localparam logic [7:0] SR1_WMASK = 8'hfc;
   localparam logic [7:0] SR2_WMASK = 8'h43;
   localparam logic [7:0] SR1_RESET = 8'h00;
   localparam logic [7:0] SR2_RESET = 8'h00;
   localparam logic [7:0] ERASED_BYTE = 8'hff;

   // Lane widths and edge counts.
   localparam logic [2:0] LW1 = 3'h1;
   localparam logic [2:0] LW2 = 3'h2;
   localparam logic [2:0] LW4 = 3'h4;
   localparam logic [5:0] LEAD_NONE = 6'h3f;
   localparam logic [2:0] NB_MAX = 3'h7;

   localparam int CLK_PERIOD_NS = 20;

   typedef struct packed {
      logic       rd;
      logic       stat;
      logic [2:0] aw;
      logic [2:0] dw;
      logic [5:0] lead;
      logic [2:0] ow;
      logic       quad;
   } sff_op_t;

   typedef struct packed {
      logic [7:0] sr1;
      logic [7:0] sr2;
      logic       pd;
   } sff_stat_t;

   typedef struct packed {
      logic       started;
      logic       opc_done;
      logic       rd_ok;
      logic [7:0] opc;
      logic [7:0] shf;
      logic [2:0] bitn;
      logic [5:0] ecnt;
      logic [2:0] obit;
   } sff_frame_t;

   typedef struct packed {
      logic       seq;
      logic       aligned;
      logic [7:0] opc;
      logic [2:0] nb;
      logic [7:0] d0;
      logic [7:0] d1;
      sff_stat_t  s1;
      sff_stat_t  s2;
   } sff_held_t;

   typedef struct packed {
      logic       hold;
      logic [3:0] dat;
      logic [3:0] oe;
   } sff_out_t;

   typedef struct packed {
      logic [2:0]  cs_s;
      logic [1:0]  wp_s;
      logic [2:0]  seq_s;
      logic        last_seq;
      logic [7:0]  sr1;
      logic [7:0]  sr2;
      logic        pd;
      logic        puw_done;
      logic [31:0] puw_cnt;
      logic [31:0] busy_cnt;
   } sff_core_t;

endpackage : sff_pkg
